// file: rtl/tbm_byte_master.sv
// Two-wire byte master: byte sequencer, bit sequencer, shift register.
// Assumes open-drain pads outside and command strobes from the same clock.
`timescale 1ns/10ps
`include "tbm_map.svh"

// Contract
// R1 - Bytes are eight bits, most significant bit first.
// R2 - One clock pulse on the clock line per data bit.
// R3 - Ninth clock carries the acknowledge, driven by the receiver.
// R4 - Data line changes only while clock line is low.
// R5 - Start is data falling with clock high, on idle or owned bus.
// R6 - Stop is data rising while clock is held high.
// R7 - Begin request with read or send issues start first.
// R8 - Repeated start is issued while still owning the bus.
// R9 - First byte after start holds seven-bit address and direction.
// R10 - Address goes out as an ordinary byte write from transmit holding.
// R11 - Software sends ten-bit addresses as two address bytes.
// R12 - Active flag during transfer; at end clear, flag event, interrupt.
// R13 - Receive holding register is loaded when the event flag sets; the code loads it at the end of the ack slot, before any requested stop.
// R14 - Software waits for the active flag to clear first.
// R15 - Clock line fall restarts own low period, held low meanwhile.
// R16 - Slave holding clock low stalls the controller as wait states.
// R17 - Enable pulse at four times serial clock, stretch aware.
// R18 - Byte sequencer turns command bits into ordered bit operations.
// R19 - A byte read issues eight bit-read operations.
// R20 - Bit operations run idle then A to D; stop idle, A to C.
// R21 - Shift register collects read bits, loads transmit byte to send.
// R22 - Slave releases data after master no-acknowledge.
// R23 - Unrequested stop or data low while driving high is lost contention.
// R24 - Acknowledge slot low when ack bit zero, high when one.
// R25 - Peer acknowledge flag is one on no-acknowledge, zero on acknowledge.
module tbm_byte_master (
  input  wire logic                       mclk_i,
  input  wire logic                       rstn_i,
  input  wire logic                       enable_i,
  input  wire logic                       event_signal_enable_i,
  input  wire logic [`TBM_PRESCALE_W-1:0] prescale_i,
  input  wire logic                       cmd_valid_i,
  input  wire logic                       begin_condition_request_i,
  input  wire logic                       end_condition_request_i,
  input  wire logic                       read_request_i,
  input  wire logic                       send_request_i,
  input  wire logic                       ack_cmd_i,
  input  wire logic [`TBM_BYTE_W-1:0]     transmit_holding_register_i,
  input  wire logic                       event_clear_i,
  input  wire logic                       scl_i,
  output logic                            scl_o,
  output logic                            scl_oe_o,
  input  wire logic                       sda_i,
  output logic                            sda_o,
  output logic                            sda_oe_o,
  output logic [`TBM_BYTE_W-1:0]          receive_holding_register_o,
  output logic                            peer_acknowledge_flag_o,
  output logic                            lost_contention_flag_o,
  output logic                            transfer_active_flag_o,
  output logic                            event_pending_o,
  output logic                            bus_busy_o,
  output logic                            irq_o
);
  import tbm_pkg::*;

  // Synchronised lines and their history
  logic [1:0] line_s;
  logic       scl_prev;
  logic       sda_prev;
  wire        scl_s = line_s[`TBM_SCL_POS];
  wire        sda_s = line_s[`TBM_SDA_POS];

  // Bit sequencer state
  tbm_bit_state_t bs;
  tbm_bit_state_t next_bs;
  logic           scl_rel;
  logic           sda_rel;
  logic           next_scl_rel;
  logic           next_sda_rel;
  logic           bit_rx;
  logic           bit_done;
  logic           clk_en;

  // Byte sequencer state
  tbm_byte_state_t ys;
  tbm_byte_state_t next_ys;
  logic [2:0]      cnt;
  logic [2:0]      next_cnt;
  logic [`TBM_BYTE_W-1:0] sr;
  logic [`TBM_BYTE_W-1:0] next_sr;
  logic [`TBM_BYTE_W-1:0] next_rhr;
  logic            next_pack;
  logic            bit_go;
  tbm_bit_cmd_t    bit_cmd;
  logic            fin;

  // Latched command bits
  logic            cmd_pend;
  logic            c_begin;
  logic            c_end;
  logic            c_rd;
  logic            c_wr;
  // A write is the fallback whenever send was requested without read
  wire             sr_load_only = c_wr;
  logic            c_ack;
  logic [`TBM_BYTE_W-1:0] c_txr;

  tbm_sync u_sync (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .line_i ({sda_i, scl_i}),
    .line_o (line_s)
  );

  // Released clock seen low means someone else is holding it
  wire stretch   = scl_rel & ~scl_s;
  wire scl_fall  = scl_prev & ~scl_s;
  wire other_low = scl_fall & scl_rel & (bs != BS_IDLE);

  tbm_clkgen u_clkgen (
    .mclk_i     (mclk_i),
    .rstn_i     (rstn_i),
    .enable_i   (enable_i),
    .prescale_i (prescale_i),
    .hold_i     (stretch),                                           // R16
    .restart_i  (other_low),                                         // R15
    .clk_en_o   (clk_en)
  );

  // Bus condition detectors on the synchronised lines
  wire start_det = scl_s & scl_prev & sda_prev & ~sda_s;
  wire stop_det  = scl_s & scl_prev & ~sda_prev & sda_s;
  wire own_stop  = (bs == BS_STO_B) | (bs == BS_STO_C) | (bs == BS_IDLE);

  // Contention: released data read low during clock high, or foreign stop
  wire lost_drive = clk_en & (bs == BS_WR_C) & sda_rel & ~sda_s;    // R23
  wire lost_stop  = stop_det & transfer_active_flag_o &
                    ~((bs == BS_STO_C) | (ys == YS_STOP && own_stop)); // R23
  wire lost       = lost_drive | lost_stop;

  // Ack slot carries the ack command bit, data bits the shift MSB
  wire bit_tx = (ys == YS_ACK) ? c_ack : sr[`TBM_MSB_POS];         // R24
  wire start_job = cmd_pend & enable_i & (ys == YS_IDLE);
  wire cmd_take  = cmd_valid_i & ~transfer_active_flag_o & ~cmd_pend &
                   (read_request_i | send_request_i |
                    end_condition_request_i);                        // R14

  // Last phase of any operation; kept apart from the phase logic
  // so the next command cannot loop back through it
  assign bit_done = clk_en & ((bs == BS_STA_D) | (bs == BS_STO_C) |
                              (bs == BS_RD_D)  | (bs == BS_WR_D));

  // Bit sequencer: levels of each phase apply on its enable pulse
  always_comb begin
    next_bs      = bs;
    next_scl_rel = scl_rel;
    next_sda_rel = sda_rel;
    if (lost) begin
      next_bs      = BS_IDLE;
      next_scl_rel = 1'b1;
      next_sda_rel = 1'b1;
    end else begin
      if (clk_en) begin
      unique case (bs)                                               // R20
        BS_IDLE: begin
          next_bs = BS_IDLE;
        end
        // Clock left as found: low means a repeated start
        BS_STA_A: begin
          next_sda_rel = 1'b1;                                       // R7 R8
          next_bs      = BS_STA_B;
        end
        BS_STA_B: begin
          next_scl_rel = 1'b1;
          next_sda_rel = 1'b1;
          next_bs      = BS_STA_C;
        end
        BS_STA_C: begin
          next_sda_rel = 1'b0;                                       // R5
          next_bs      = BS_STA_D;
        end
        BS_STA_D: begin
          next_scl_rel = 1'b0;
          next_bs      = BS_IDLE;
        end
        BS_STO_A: begin
          next_scl_rel = 1'b0;
          next_sda_rel = 1'b0;
          next_bs      = BS_STO_B;
        end
        BS_STO_B: begin
          next_scl_rel = 1'b1;
          next_bs      = BS_STO_C;
        end
        BS_STO_C: begin
          next_sda_rel = 1'b1;                                       // R6
          next_bs      = BS_IDLE;
        end
        BS_RD_A: begin
          next_scl_rel = 1'b0;
          next_sda_rel = 1'b1;
          next_bs      = BS_RD_B;
        end
        BS_RD_B: begin
          next_scl_rel = 1'b1;                                       // R2
          next_bs      = BS_RD_C;
        end
        BS_RD_C: begin
          next_bs      = BS_RD_D;
        end
        BS_RD_D: begin
          next_scl_rel = 1'b0;
          next_bs      = BS_IDLE;
        end
        BS_WR_A: begin
          next_scl_rel = 1'b0;
          next_sda_rel = bit_tx;                                     // R4
          next_bs      = BS_WR_B;
        end
        BS_WR_B: begin
          next_scl_rel = 1'b1;                                       // R2
          next_bs      = BS_WR_C;
        end
        BS_WR_C: begin
          next_bs      = BS_WR_D;
        end
        BS_WR_D: begin
          next_scl_rel = 1'b0;
          next_bs      = BS_IDLE;
        end
      endcase
      end
      // A new operation starts in the cycle of the last phase
      if (bit_go) begin
        unique case (bit_cmd)
          BC_START: next_bs = BS_STA_A;
          BC_STOP:  next_bs = BS_STO_A;
          BC_READ:  next_bs = BS_RD_A;
          BC_WRITE: next_bs = BS_WR_A;
          default:  next_bs = BS_IDLE;
        endcase
      end
    end
  end

  // Byte sequencer: commands become ordered bit operations
  always_comb begin
    next_ys   = ys;
    next_cnt  = cnt;
    next_sr   = sr;
    next_rhr  = receive_holding_register_o;
    next_pack = peer_acknowledge_flag_o;
    bit_go    = 1'b0;
    bit_cmd   = BC_NOP;
    fin       = 1'b0;
    if (lost) begin
      next_ys = YS_IDLE;
    end else begin
      unique case (ys)                                               // R18
        YS_IDLE: begin
          if (start_job) begin
            bit_go = 1'b1;
            if (c_begin) begin
              bit_cmd = BC_START;                                    // R7
              next_ys = YS_START;
            end else if (c_rd) begin
              bit_cmd  = BC_READ;
              next_ys  = YS_READ;
              next_cnt = `TBM_BIT_LAST;                              // R19
            end else if (cmd_pend & ~c_end | sr_load_only) begin
              bit_cmd  = BC_WRITE;
              next_ys  = YS_WRITE;
              next_sr  = c_txr;                                      // R10 R21
              next_cnt = `TBM_BIT_LAST;
            end else begin
              bit_cmd = BC_STOP;
              next_ys = YS_STOP;
            end
          end
        end
        YS_START: begin
          if (bit_done) begin
            bit_go   = 1'b1;
            next_cnt = `TBM_BIT_LAST;
            if (c_rd) begin
              bit_cmd = BC_READ;
              next_ys = YS_READ;
            end else begin
              bit_cmd = BC_WRITE;                                    // R9
              next_ys = YS_WRITE;
              next_sr = c_txr;                                       // R21
            end
          end
        end
        YS_WRITE, YS_READ: begin
          if (bit_done) begin
            bit_go  = 1'b1;
            next_sr = {sr[`TBM_MSB_POS-1:0],
                       (ys == YS_READ) & bit_rx};                    // R1 R21
            if (cnt == '0) begin
              next_ys = YS_ACK;                                      // R3
              bit_cmd = (ys == YS_READ) ? BC_WRITE : BC_READ;
            end else begin
              next_cnt = cnt - 3'h1;
              bit_cmd  = (ys == YS_READ) ? BC_READ : BC_WRITE;       // R19
            end
          end
        end
        YS_ACK: begin
          if (bit_done) begin
            if (c_rd) begin
              next_rhr = sr;                                         // R13
            end else begin
              next_pack = bit_rx;                                    // R25
            end
            if (c_end) begin
              bit_go  = 1'b1;
              bit_cmd = BC_STOP;
              next_ys = YS_STOP;
            end else begin
              fin     = 1'b1;
              next_ys = YS_IDLE;
            end
          end
        end
        YS_STOP: begin
          if (bit_done) begin
            fin     = 1'b1;
            next_ys = YS_IDLE;
          end
        end
        default: next_ys = YS_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      bs       <= BS_IDLE;
      scl_rel  <= 1'b1;
      sda_rel  <= 1'b1;
      bit_rx   <= 1'b1;
    end else begin
      scl_prev <= scl_s;
      sda_prev <= sda_s;
      bs       <= next_bs;
      scl_rel  <= next_scl_rel;
      sda_rel  <= next_sda_rel;
      if (clk_en && (bs == BS_RD_C || bs == BS_WR_C)) begin
        bit_rx <= sda_s;                                             // R4
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ys                         <= YS_IDLE;
      cnt                        <= '0;
      sr                         <= `TBM_BYTE_RST;
      receive_holding_register_o <= `TBM_BYTE_RST;
      peer_acknowledge_flag_o    <= 1'b0;
    end else begin
      ys                         <= next_ys;
      cnt                        <= next_cnt;
      sr                         <= next_sr;
      receive_holding_register_o <= next_rhr;
      peer_acknowledge_flag_o    <= next_pack;
    end
  end

  // Command latch; request bits drop automatically when the job ends, the ack bit is kept
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd_pend <= 1'b0;
      c_begin  <= 1'b0;
      c_end    <= 1'b0;
      c_rd     <= 1'b0;
      c_wr     <= 1'b0;
      c_ack    <= 1'b0;
      c_txr    <= `TBM_BYTE_RST;
    end else if (cmd_take) begin
      cmd_pend <= 1'b1;
      c_begin  <= begin_condition_request_i;
      c_end    <= end_condition_request_i;
      c_rd     <= read_request_i;
      c_wr     <= send_request_i & ~read_request_i;
      c_ack    <= ack_cmd_i;
      c_txr    <= transmit_holding_register_i;
    end else if (start_job) begin
      cmd_pend <= 1'b0;
    end else if (fin | lost) begin
      c_begin  <= 1'b0;
      c_end    <= 1'b0;
      c_rd     <= 1'b0;
      c_wr     <= 1'b0;
    end
  end

  // Status flags; a set in the clearing cycle wins, except on the active flag where the clear wins
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      transfer_active_flag_o <= 1'b0;
      event_pending_o        <= 1'b0;
      lost_contention_flag_o <= 1'b0;
      bus_busy_o             <= 1'b0;
      irq_o                  <= 1'b0;
    end else begin
      transfer_active_flag_o <= (transfer_active_flag_o | cmd_take) &
                                ~(fin | lost);                       // R12
      event_pending_o        <= (fin | lost) |
                                (event_pending_o & ~event_clear_i);  // R12
      lost_contention_flag_o <= lost |
                                (lost_contention_flag_o & ~cmd_take); // R23
      bus_busy_o             <= start_det | (bus_busy_o & ~stop_det);
      irq_o                  <= event_pending_o & event_signal_enable_i;
    end
  end

  // Open-drain pads: the enable pulls the line low, the level is always 0
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_o    <= 1'b0;
      sda_o    <= 1'b0;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      scl_o    <= 1'b0;
      sda_o    <= 1'b0;
      scl_oe_o <= ~next_scl_rel;                                     // R15
      sda_oe_o <= ~next_sda_rel;                                     // R4
    end
  end

endmodule : tbm_byte_master

// file: rtl/tbm_map.svh
// Constants of the two-wire byte master: counts, reset levels, positions.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef TBM_MAP_SVH
`define TBM_MAP_SVH

`define TBM_BYTE_W        8
`define TBM_BIT_LAST      3'h7
`define TBM_MSB_POS       7
`define TBM_PRESCALE_W    16
`define TBM_LINE_IDLE     2'h3
`define TBM_SCL_POS       0
`define TBM_SDA_POS       1
`define TBM_BYTE_RST      8'h00

`endif

// file: rtl/tbm_pkg.sv
// Types shared by the two-wire byte master design files.
// Assumes nothing beyond a SystemVerilog compiler.
package tbm_pkg;

  typedef enum logic [2:0] {
    BC_NOP,
    BC_START,
    BC_STOP,
    BC_READ,
    BC_WRITE
  } tbm_bit_cmd_t;

  typedef enum logic [4:0] {
    BS_IDLE,
    BS_STA_A, BS_STA_B, BS_STA_C, BS_STA_D,
    BS_STO_A, BS_STO_B, BS_STO_C,
    BS_RD_A,  BS_RD_B,  BS_RD_C,  BS_RD_D,
    BS_WR_A,  BS_WR_B,  BS_WR_C,  BS_WR_D
  } tbm_bit_state_t;

  typedef enum logic [2:0] {
    YS_IDLE,
    YS_START,
    YS_WRITE,
    YS_READ,
    YS_ACK,
    YS_STOP
  } tbm_byte_state_t;

endpackage : tbm_pkg

// file: rtl/tbm_sync.sv
// Three-stage input synchroniser for the two bus lines.
// Assumes asynchronous line levels; output moves once stages two and three agree.
`timescale 1ns/10ps
`include "tbm_map.svh"

module tbm_sync (
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  input  wire logic [1:0] line_i,
  output logic      [1:0] line_o
);
  import tbm_pkg::*;

  logic [1:0] stage1;
  logic [1:0] stage2;
  logic [1:0] stage3;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_line
      always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          stage1[g] <= 1'b1;
          stage2[g] <= 1'b1;
          stage3[g] <= 1'b1;
          line_o[g] <= 1'b1;
        end else begin
          stage1[g] <= line_i[g];
          stage2[g] <= stage1[g];
          stage3[g] <= stage2[g];
          // Only an agreed level is passed on, so one-cycle glitches die here
          if (stage2[g] == stage3[g]) begin
            line_o[g] <= stage3[g];
          end
        end
      end
    end
  endgenerate

endmodule : tbm_sync

// file: rtl/tbm_clkgen.sv
// Quarter-bit clock enable generator with clock-stretch hold.
// Assumes synchronised line levels and a prescale held steady while enabled.
`timescale 1ns/10ps
`include "tbm_map.svh"

module tbm_clkgen (
  input  wire logic                       mclk_i,
  input  wire logic                       rstn_i,
  input  wire logic                       enable_i,
  input  wire logic [`TBM_PRESCALE_W-1:0] prescale_i,
  input  wire logic                       hold_i,
  input  wire logic                       restart_i,
  output logic                            clk_en_o
);
  import tbm_pkg::*;

  logic [`TBM_PRESCALE_W-1:0] cnt;

  wire cnt_zero = (cnt == '0);
  wire reload   = cnt_zero | ~enable_i | restart_i;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt      <= '0;
      clk_en_o <= 1'b0;
    end else if (hold_i & ~restart_i) begin
      cnt      <= cnt;                                               // R16
      clk_en_o <= 1'b0;
    end else begin
      cnt      <= reload ? prescale_i : cnt - 1'b1;                  // R17
      clk_en_o <= enable_i & (cnt_zero | restart_i);                 // R15
    end
  end

endmodule : tbm_clkgen

// file: dv/tbm_checker.sv
// Port-level checks of the two-wire byte master.
// Assumes a bind onto tbm_byte_master run with a prescale of 2.
`timescale 1ns/10ps
module tbm_checker (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic enable_i,
  input wire logic event_signal_enable_i,
  input wire logic cmd_valid_i,
  input wire logic end_condition_request_i,
  input wire logic read_request_i,
  input wire logic send_request_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic scl_oe_o,
  input wire logic sda_oe_o,
  input wire logic transfer_active_flag_o,
  input wire logic event_pending_o,
  input wire logic bus_busy_o,
  input wire logic irq_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  logic cmd_ok;
  assign cmd_ok = cmd_valid_i & enable_i &
                  (read_request_i | send_request_i | end_condition_request_i);
  a_cmd_sets_active: assert property (
    cmd_ok && !transfer_active_flag_o && !event_pending_o
    |=> transfer_active_flag_o) else $error("command not taken");
  a_end_flags_event: assert property (
    $fell(transfer_active_flag_o) |-> event_pending_o)
    else $error("job end without event");
  a_irq_raise: assert property (
    event_pending_o && event_signal_enable_i |=> irq_o)
    else $error("irq missing");
  a_irq_quiet: assert property (
    !(event_pending_o && event_signal_enable_i) |=> !irq_o)
    else $error("irq without cause");
  // Data moves with clock released only as a start or a stop
  a_sda_edge_kind: assert property (
    $changed(sda_oe_o) && !scl_oe_o && !$past(scl_oe_o) |-> scl_i)
    else $error("data moved with clock low and released");
  a_start_busy: assert property (
    $fell(sda_i) && scl_i |-> ##[1:8] bus_busy_o)
    else $error("start not seen");
  a_stop_idle: assert property (
    $rose(sda_i) && scl_i |-> ##[1:8] !bus_busy_o)
    else $error("stop not seen");
  a_stretch_wait: assert property (
    (!scl_oe_o && !scl_i) [*2] |=> $stable(sda_oe_o))
    else $error("moved on during stretch");
  a_scl_high_len: assert property (
    $fell(scl_oe_o) && scl_i |-> !scl_oe_o [*5])
    else $error("clock high too short");
endmodule : tbm_checker

// file: dv/tbm_slave_model.sv
// Behavioural addressed slave on the wired-AND two-wire bus.
// Assumes wire levels in; pulls out are high while it pulls low.
`timescale 1ns/10ps
module tbm_slave_model #(
  parameter logic [6:0] ADDR = 7'h51
) (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       stretch_i,
  input  wire logic [7:0] tx_byte_i,
  output logic            scl_hold_o,
  output logic            sda_pull_o,
  output logic      [7:0] rx_byte_o,
  output logic            master_ack_o
);
  logic [7:0] sh = 8'h00;
  int         cnt = 0;
  logic       sel = 1'h0;
  logic       rd = 1'h0;
  logic       first = 1'h0;
  logic       pull;
  initial begin
    scl_hold_o = 1'h0;
    sda_pull_o = 1'h0;
    rx_byte_o = 8'h00;
    master_ack_o = 1'h0;
  end
  always @(negedge sda_i) if (scl_i === 1'h1) begin
    cnt = 0;
    first = 1'h1;
    sel = 1'h0;
  end
  always @(posedge sda_i) if (scl_i === 1'h1) sel = 1'h0;
  always @(posedge scl_i) begin
    if (cnt < 8) sh = {sh[6:0], sda_i};
    else if (rd) begin
      master_ack_o = sda_i;
      if (sda_i) sel = 1'h0;
    end
    cnt++;
  end
  always @(negedge scl_i) begin
    if (stretch_i) begin
      scl_hold_o = 1'h1;
      scl_hold_o <= #400 1'h0;
    end
    if (cnt == 9) cnt = 0;
    pull = 1'h0;
    if (cnt == 8) begin
      rx_byte_o = sh;
      if (first) begin
        sel = (sh[7:1] == ADDR);
        rd = sh[0];
        first = 1'h0;
        pull = sel;
      end else pull = sel & ~rd;
    end else if (sel & rd & ~first) pull = ~tx_byte_i[7-cnt];
    // Hold time keeps the data change clear of the falling clock
    sda_pull_o <= #15 pull;
  end
endmodule : tbm_slave_model

// file: dv/tb_tbm_byte_master.sv
// Command-level bench of the two-wire byte master with one slave.
// Assumes the slave model and checker files compiled before this one.
`timescale 1ns/10ps
module tb_tbm_byte_master;
  logic       mclk_i = 1'h0;
  logic       rstn_i = 1'h0;
  logic       event_signal_enable = 1'h1;
  logic       cmd_v = 1'h0;
  logic       clr = 1'h0;
  logic       stretch = 1'h0;
  logic       fight = 1'h0;
  logic       b = 1'h0, e = 1'h0, r = 1'h0, s = 1'h0, ack = 1'h0;
  logic [7:0] transmit_holding_register = 8'h00, rhr, rx_seen;
  logic       scl_w, sda_w, scl_o, sda_o, scl_oe, sda_oe, hold, pull;
  logic       peer, lost, active, pend, busy, irq, m_ack;
  int         num_errors = 0, n_tests = 0;
  assign scl_w = ~(scl_oe | hold);
  assign sda_w = ~(sda_oe | pull | fight);
  always #5 mclk_i = ~mclk_i;
  tbm_byte_master DUT (.mclk_i(mclk_i), .rstn_i(rstn_i), .enable_i(1'h1),
    .event_signal_enable_i(event_signal_enable), .prescale_i(16'h0002), .cmd_valid_i(cmd_v),
    .begin_condition_request_i(b), .end_condition_request_i(e),
    .read_request_i(r), .send_request_i(s), .ack_cmd_i(ack),
    .transmit_holding_register_i(transmit_holding_register), .event_clear_i(clr), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .receive_holding_register_o(rhr),
    .peer_acknowledge_flag_o(peer), .lost_contention_flag_o(lost),
    .transfer_active_flag_o(active), .event_pending_o(pend),
    .bus_busy_o(busy), .irq_o(irq));
  tbm_slave_model u_slave (.scl_i(scl_w), .sda_i(sda_w), .stretch_i(stretch),
    .tx_byte_i(8'h5A), .scl_hold_o(hold), .sda_pull_o(pull),
    .rx_byte_o(rx_seen), .master_ack_o(m_ack));
  task automatic report_and_stop();
    if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic check(input string nm, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : step
  // Bits are begin, end, read, send, ack; waits for the job to end
  task automatic cmd(input logic [4:0] bits, input logic [7:0] tx);
    int i;
    @(posedge mclk_i);
    clr <= 1'h1;
    @(posedge mclk_i);
    clr <= 1'h0;
    {b, e, r, s, ack} <= bits;
    transmit_holding_register <= tx;
    cmd_v <= 1'h1;
    @(posedge mclk_i);
    cmd_v <= 1'h0;
    step(1);
    check("active", active, 1'h1);
    i = 0;
    while (active !== 1'h0 && i < 4000) begin
      step(1);
      i++;
    end
    if (i == 4000) begin
      num_errors++;
      report_and_stop();
    end
    check("event", pend, 1'h1);
    step(1);
    check("irq", irq, event_signal_enable);
  endtask : cmd
  initial begin
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1'h1;
    step(5);
    cmd(5'h12, 8'hA2);
    check("slave_rx", rx_seen, 8'hA2);
    check("peer_ack", peer, 1'h0);
    check("busy", busy, 1'h1);
    event_signal_enable <= 1'h0;
    stretch <= 1'h1;
    cmd(5'h02, 8'h3C);
    check("stretch_rx", rx_seen, 8'h3C);
    event_signal_enable <= 1'h1;
    stretch <= 1'h0;
    cmd(5'h12, 8'hA3);
    check("rd_addr_ack", peer, 1'h0);
    cmd(5'h04, 8'h00);
    check("rhr_ack", rhr, 8'h5A);
    check("master_ack", m_ack, 1'h0);
    cmd(5'h0D, 8'h00);
    check("rhr_nack", rhr, 8'h5A);
    check("master_nack", m_ack, 1'h1);
    step(10);
    check("busy_stop", busy, 1'h0);
    cmd(5'h12, 8'hA4);
    check("peer_nack", peer, 1'h1);
    cmd(5'h08, 8'h00);
    step(10);
    check("busy_stop2", busy, 1'h0);
    cmd(5'h12, 8'hA2);
    fight <= 1'h1;
    cmd(5'h02, 8'hFF);
    check("lost", lost, 1'h1);
    fight <= 1'h0;
    step(10);
    check("busy_lost", busy, 1'h0);
    rstn_i <= 1'h0;
    step(2);
    check("rst_flags", {active, pend, irq, scl_oe, sda_oe}, 8'h00);
    rstn_i <= 1'h1;
    step(5);
    cmd(5'h12, 8'hA2);
    check("rst_rx", rx_seen, 8'hA2);
    cmd(5'h0A, 8'hC3);
    check("wr_stop_rx", rx_seen, 8'hC3);
    check("wr_stop_ack", peer, 1'h0);
    step(10);
    check("busy_wr_stop", busy, 1'h0);
    report_and_stop();
  end
endmodule : tb_tbm_byte_master
bind tbm_byte_master tbm_checker u_chk (.mclk_i, .rstn_i, .enable_i,
  .event_signal_enable_i, .cmd_valid_i, .end_condition_request_i,
  .read_request_i, .send_request_i, .scl_i, .sda_i, .scl_oe_o, .sda_oe_o,
  .transfer_active_flag_o, .event_pending_o, .bus_busy_o, .irq_o);
